// ===== include/dwc_pkg.sv
// Shared constants and types for the disk write command engine
package dwc_pkg;

    typedef logic [15:0] dwc_word_type;
    typedef logic [7:0]  dwc_byte_type;

    // ****************************************
    // Task-file and host status word offsets
    // ****************************************
    localparam logic [9:0] TF_DATA_OFS     = 10'h1F0;
    localparam logic [9:0] TF_FAULT_OFS    = 10'h1F1;
    localparam logic [9:0] TF_COUNT_OFS    = 10'h1F2;
    localparam logic [9:0] TF_SNUM_OFS     = 10'h1F3;
    localparam logic [9:0] TF_CYL_LO_OFS   = 10'h1F4;
    localparam logic [9:0] TF_CYL_HI_OFS   = 10'h1F5;
    localparam logic [9:0] TF_DEV_HEAD_OFS = 10'h1F6;
    localparam logic [9:0] TF_CMD_OFS      = 10'h1F7;
    localparam logic [9:0] HOST_STATUS_OFS = 10'h1F8;

    // ****************************************
    // Command codes and register fields
    // ****************************************
    localparam dwc_byte_type CMD_WRITE_SEC   = 8'h30;
    localparam dwc_byte_type CMD_WRITE_MULTI = 8'hC5;
    localparam dwc_byte_type CMD_SET_MULTI   = 8'hC6;
    localparam int           CMD_RETRY_BIT   = 0;
    localparam int           ST_BSY          = 7;
    localparam int           ST_DRDY         = 6;
    localparam int           ST_DSC          = 4;
    localparam int           ST_DRQ          = 3;
    localparam int           ST_ERR          = 0;
    localparam dwc_byte_type FAULT_ABORT     = 8'h04;
    localparam int           DH_LBA_BIT      = 6;
    localparam int           HST_INTRQ_BIT   = 0;
    localparam int           HST_REFUSED_BIT = 1;
    localparam logic [8:0]   MAX_SECTORS     = 9'h100;
    localparam dwc_word_type CRC_POLY        = 16'h1021;
    localparam dwc_word_type CRC_INIT        = 16'hFFFF;
    localparam logic [1:0]   HTRANS_NONSEQ   = 2'h2;

    // ****************************************
    // State encodings
    // ****************************************
    typedef enum logic [2:0] {
        DS_IDLE, DS_SEEK, DS_SEEK_WAIT, DS_DATA, DS_CRC, DS_ECC, DS_COMMIT, DS_WAIT
    } dwc_dev_state_type;

    typedef enum logic [2:0] {
        HS_IDLE, HS_LATCH, HS_STROBE, HS_CAPTURE, HS_RESP
    } dwc_host_state_type;

endpackage

// ===== include/dwc_if.sv
// Task-file link between the host controller and the drive
`timescale 1ns/10ps
interface dwc_if;
    logic [2:0]            addr;
    logic                  wr;
    logic                  rd;
    dwc_pkg::dwc_word_type wdata;
    dwc_pkg::dwc_word_type rdata;
    logic                  iordy;
    logic                  intrq;

    modport dev  (input addr, wr, rd, wdata, output rdata, iordy, intrq);
    modport host (output addr, wr, rd, wdata, input rdata, iordy, intrq);
endinterface

// ===== hdl/dwc_crc16.sv
// Running CRC over the data words of one sector
`timescale 1ns/10ps
module dwc_crc16 (
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    input  wire logic            i_clear,
    input  wire logic            i_valid,
    input  dwc_pkg::dwc_word_type i_data,
    output dwc_pkg::dwc_word_type o_crc
);
    import dwc_pkg::*;

    typedef struct packed {
        dwc_word_type crc;
    } dwc_crc_regs_type;

    dwc_crc_regs_type crc_ff;
    dwc_crc_regs_type nxt_crc;

    always_comb begin
        dwc_word_type c;
        c = crc_ff.crc;
        nxt_crc = crc_ff;
        if (i_clear) begin
            nxt_crc.crc = CRC_INIT;
        end else if (i_valid) begin
            for (int i = 15; i >= 0; i--) begin
                c = {c[14:0], 1'b0} ^ ((c[15] ^ i_data[i]) ? CRC_POLY : 16'h0000);
            end
            nxt_crc.crc = c;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            crc_ff <= '{crc: CRC_INIT};
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    assign o_crc = crc_ff.crc;
endmodule

// ===== hdl/dwc_device.sv
// Drive end: task file and sector/multiple write command engine
//
// Functional notes
// - 0x30/0x31 write; bit0 set disables retry
// - Up to 256 sectors from count register
// - Start address from head, cylinder, sector
// - Seek first when off the target track
// - Record data, then CRC and ECC words
// - Success leaves last written sector address
// - Error stops at failing sector address
// - Error leaves untransferred sectors in count
// - 0xC5 writes whole blocks between interrupts
// - Multiple write interrupts once per block; the code interrupts at each block start and once more at completion
// - Data request set only at block start
// - Count register holds total sectors requested
// - Short counts allowed; host never sends zero
// - Remainder sectors go as final partial block
// - No block size set: abort command
// - Error stops mid-block, no further blocks
// - Interrupt whenever a block's data request rises
// - Host retries singly to locate failed sector
// - After error, drive select and fault valid
// - Host sets block size before multiple write
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
module dwc_device #(
    parameter int P_SECTOR_WORDS = 256,
    parameter int P_SECT_PER_TRK = 63,
    parameter int P_HEADS        = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    dwc_if.dev                    tf_bus,
    output logic                  o_med_wvalid,
    output dwc_pkg::dwc_word_type o_med_wdata,
    output logic                  o_med_commit,
    output logic [15:0]           o_med_cyl,
    output logic [3:0]            o_med_head,
    output dwc_pkg::dwc_byte_type o_med_sector,
    output logic                  o_med_lba_mode,
    output logic                  o_med_no_retry,
    input  wire logic             i_med_done,
    input  wire logic             i_med_error,
    input  dwc_pkg::dwc_byte_type i_med_fault,
    output logic                  o_seek_req,
    output logic [15:0]           o_seek_cyl,
    input  wire logic             i_seek_done
);
    import dwc_pkg::*;

    localparam int WCW = $clog2(P_SECTOR_WORDS);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        dwc_dev_state_type st;
        dwc_byte_type      fault;
        dwc_byte_type      count;
        dwc_byte_type      snum;
        dwc_byte_type      cyl_lo;
        dwc_byte_type      cyl_hi;
        dwc_byte_type      dev_head;
        logic              bsy;
        logic              drq;
        logic              err;
        logic              intrq;
        logic              iordy;
        logic              multi;
        logic              no_retry;
        logic [8:0]        remaining;
        logic [8:0]        block_left;
        dwc_byte_type      block_size;
        logic [WCW-1:0]    word_cnt;
        logic [15:0]       cur_cyl;
        dwc_word_type      ecc;
        dwc_word_type      rdata;
        dwc_word_type      med_wdata;
        logic              med_wvalid;
        logic              commit;
        logic              seek_req;
    } dwc_dev_regs_type;

    dwc_dev_regs_type dev_ff;
    dwc_dev_regs_type nxt_dev;
    logic             crc_clear;
    logic             crc_valid;
    dwc_word_type     crc_val;

    dwc_crc16 u_crc (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clear  (crc_clear),
        .i_valid  (crc_valid),
        .i_data   (tf_bus.wdata),
        .o_crc    (crc_val)
    );

    // Packed as {head, cyl_hi, cyl_lo, sector}, which is also the LBA order
    function automatic logic [27:0] next_addr(input logic [27:0] a, input logic lba);
        logic [3:0]  head;
        logic [15:0] cyl;
        logic [7:0]  sn;
        head = a[27:24];
        cyl  = a[23:8];
        sn   = a[7:0];
        if (lba) begin
            return a + 28'h0000001;
        end
        if (sn == 8'(P_SECT_PER_TRK)) begin
            sn = 8'h01;
            if (head == 4'(P_HEADS - 1)) begin
                head = 4'h0;
                cyl  = cyl + 16'h0001;
            end else begin
                head = head + 4'h1;
            end
        end else begin
            sn = sn + 8'h01;
        end
        return {head, cyl, sn};
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        dwc_byte_type status;
        logic [27:0]  addr;
        logic         cmd_wr;
        logic         data_wr;
        status  = '0;
        addr    = {dev_ff.dev_head[3:0], dev_ff.cyl_hi, dev_ff.cyl_lo, dev_ff.snum};
        cmd_wr  = tf_bus.wr && (tf_bus.addr == TF_CMD_OFS[2:0]);
        data_wr = tf_bus.wr && (tf_bus.addr == TF_DATA_OFS[2:0])
                  && (dev_ff.st == DS_DATA) && dev_ff.iordy;
        nxt_dev = dev_ff;
        nxt_dev.med_wvalid = 1'b0;
        nxt_dev.commit     = 1'b0;
        nxt_dev.seek_req   = 1'b0;
        crc_clear = 1'b0;
        crc_valid = 1'b0;

        status[ST_BSY]  = dev_ff.bsy;
        status[ST_DRDY] = 1'b1;
        status[ST_DSC]  = 1'b1;
        status[ST_DRQ]  = dev_ff.drq;
        status[ST_ERR]  = dev_ff.err;

        if (tf_bus.rd) begin
            case (tf_bus.addr)
                TF_FAULT_OFS[2:0]:    nxt_dev.rdata = {8'h00, dev_ff.fault};
                TF_COUNT_OFS[2:0]:    nxt_dev.rdata = {8'h00, dev_ff.count};
                TF_SNUM_OFS[2:0]:     nxt_dev.rdata = {8'h00, dev_ff.snum};
                TF_CYL_LO_OFS[2:0]:   nxt_dev.rdata = {8'h00, dev_ff.cyl_lo};
                TF_CYL_HI_OFS[2:0]:   nxt_dev.rdata = {8'h00, dev_ff.cyl_hi};
                TF_DEV_HEAD_OFS[2:0]: nxt_dev.rdata = {8'h00, dev_ff.dev_head};
                TF_CMD_OFS[2:0]: begin
                    nxt_dev.rdata = {8'h00, status};
                    nxt_dev.intrq = 1'b0;
                end
                default:              nxt_dev.rdata = 16'h0000;
            endcase
        end

        // Address/count registers are frozen while a command owns them
        if (tf_bus.wr && (dev_ff.st == DS_IDLE)) begin
            case (tf_bus.addr)
                TF_COUNT_OFS[2:0]:    nxt_dev.count    = tf_bus.wdata[7:0];
                TF_SNUM_OFS[2:0]:     nxt_dev.snum     = tf_bus.wdata[7:0];
                TF_CYL_LO_OFS[2:0]:   nxt_dev.cyl_lo   = tf_bus.wdata[7:0];
                TF_CYL_HI_OFS[2:0]:   nxt_dev.cyl_hi   = tf_bus.wdata[7:0];
                TF_DEV_HEAD_OFS[2:0]: nxt_dev.dev_head = tf_bus.wdata[7:0];
                default: ;
            endcase
        end

        case (dev_ff.st)
            DS_IDLE: begin
                if (cmd_wr) begin
                    nxt_dev.err      = 1'b0;
                    nxt_dev.fault    = 8'h00;
                    nxt_dev.no_retry = tf_bus.wdata[CMD_RETRY_BIT];
                    nxt_dev.remaining = (dev_ff.count == 8'h00) ? MAX_SECTORS
                                        : {1'b0, dev_ff.count};
                    nxt_dev.block_left = 9'h000;
                    if ((tf_bus.wdata[7:1] == CMD_WRITE_SEC[7:1])
                        || ((tf_bus.wdata[7:0] == CMD_WRITE_MULTI)
                            && (dev_ff.block_size != 8'h00))) begin
                        nxt_dev.multi = (tf_bus.wdata[7:0] == CMD_WRITE_MULTI);
                        nxt_dev.bsy   = 1'b1;
                        nxt_dev.st    = DS_SEEK;
                    end else if (tf_bus.wdata[7:0] == CMD_SET_MULTI) begin
                        // Zero count disables multiple mode
                        nxt_dev.block_size = dev_ff.count;
                        nxt_dev.intrq      = 1'b1;
                    end else begin
                        nxt_dev.err   = 1'b1;
                        nxt_dev.fault = FAULT_ABORT;
                        nxt_dev.intrq = 1'b1;
                    end
                end
            end
            DS_SEEK: begin
                if ({dev_ff.cyl_hi, dev_ff.cyl_lo} != dev_ff.cur_cyl) begin
                    nxt_dev.seek_req = 1'b1;
                    nxt_dev.st       = DS_SEEK_WAIT;
                end else begin
                    crc_clear      = 1'b1;
                    nxt_dev.ecc    = 16'h0000;
                    nxt_dev.iordy  = 1'b1;
                    nxt_dev.word_cnt = '0;
                    nxt_dev.st     = DS_DATA;
                    if (dev_ff.block_left == 9'h000) begin
                        nxt_dev.block_left = (dev_ff.multi
                            && (dev_ff.remaining > {1'b0, dev_ff.block_size}))
                            ? {1'b0, dev_ff.block_size}
                            : (dev_ff.multi ? dev_ff.remaining : 9'h001);
                        nxt_dev.drq   = 1'b1;
                        nxt_dev.bsy   = 1'b0;
                        nxt_dev.intrq = 1'b1;
                    end
                end
            end
            DS_SEEK_WAIT: begin
                if (i_seek_done) begin
                    nxt_dev.cur_cyl = {dev_ff.cyl_hi, dev_ff.cyl_lo};
                    nxt_dev.st      = DS_SEEK;
                end
            end
            DS_DATA: begin
                if (data_wr) begin
                    crc_valid          = 1'b1;
                    nxt_dev.med_wvalid = 1'b1;
                    nxt_dev.med_wdata  = tf_bus.wdata;
                    nxt_dev.ecc        = dev_ff.ecc ^ tf_bus.wdata;
                    nxt_dev.word_cnt   = dev_ff.word_cnt + WCW'(1);
                    if (dev_ff.word_cnt == WCW'(P_SECTOR_WORDS - 1)) begin
                        nxt_dev.iordy = 1'b0;
                        nxt_dev.st    = DS_CRC;
                        if (dev_ff.block_left == 9'h001) begin
                            nxt_dev.drq = 1'b0;
                            nxt_dev.bsy = 1'b1;
                        end
                    end
                end
            end
            DS_CRC: begin
                nxt_dev.med_wvalid = 1'b1;
                nxt_dev.med_wdata  = crc_val;
                nxt_dev.st         = DS_ECC;
            end
            DS_ECC: begin
                nxt_dev.med_wvalid = 1'b1;
                nxt_dev.med_wdata  = dev_ff.ecc;
                nxt_dev.st         = DS_COMMIT;
            end
            DS_COMMIT: begin
                nxt_dev.commit = 1'b1;
                nxt_dev.st     = DS_WAIT;
            end
            DS_WAIT: begin
                if (i_med_done) begin
                    if (i_med_error || (dev_ff.remaining == 9'h001)) begin
                        // Error keeps the failing address; no further block
                        nxt_dev.err   = i_med_error;
                        nxt_dev.fault = i_med_error ? i_med_fault : 8'h00;
                        nxt_dev.count = i_med_error ? dev_ff.remaining[7:0] : 8'h00;
                        nxt_dev.drq   = 1'b0;
                        nxt_dev.bsy   = 1'b0;
                        nxt_dev.intrq = 1'b1;
                        nxt_dev.block_left = 9'h000;
                        nxt_dev.st    = DS_IDLE;
                    end else begin
                        addr = next_addr(addr, dev_ff.dev_head[DH_LBA_BIT]);
                        nxt_dev.dev_head[3:0] = addr[27:24];
                        nxt_dev.cyl_hi     = addr[23:16];
                        nxt_dev.cyl_lo     = addr[15:8];
                        nxt_dev.snum       = addr[7:0];
                        nxt_dev.remaining  = dev_ff.remaining - 9'h001;
                        nxt_dev.block_left = dev_ff.block_left - 9'h001;
                        nxt_dev.st         = DS_SEEK;
                    end
                end
            end
            default: nxt_dev.st = DS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            dev_ff <= '0;
        end else begin
            dev_ff <= nxt_dev;
        end
    end

    assign tf_bus.rdata   = dev_ff.rdata;
    assign tf_bus.iordy   = dev_ff.iordy;
    assign tf_bus.intrq   = dev_ff.intrq;
    assign o_med_wvalid   = dev_ff.med_wvalid;
    assign o_med_wdata    = dev_ff.med_wdata;
    assign o_med_commit   = dev_ff.commit;
    assign o_med_cyl      = {dev_ff.cyl_hi, dev_ff.cyl_lo};
    assign o_med_head     = dev_ff.dev_head[3:0];
    assign o_med_sector   = dev_ff.snum;
    assign o_med_lba_mode = dev_ff.dev_head[DH_LBA_BIT];
    assign o_med_no_retry = dev_ff.no_retry;
    assign o_seek_req     = dev_ff.seek_req;
    assign o_seek_cyl     = {dev_ff.cyl_hi, dev_ff.cyl_lo};
endmodule

// ===== hdl/dwc_host.sv
// Host end: AHB-Lite window onto the drive's task file
`timescale 1ns/10ps
module dwc_host (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic [31:0]      o_hrdata,
    output logic             o_hresp,
    dwc_if.host              tf_bus
);
    import dwc_pkg::*;

    typedef struct packed {
        dwc_host_state_type st;
        logic [9:0]         idx;
        logic               write;
        dwc_word_type       wdata;
        logic [31:0]        hrdata;
        dwc_byte_type       sc_shadow;
        logic               refused;
    } dwc_host_regs_type;

    dwc_host_regs_type host_ff;
    dwc_host_regs_type nxt_host;
    logic              accept;
    logic              go;
    logic              tf_hit;

    // Only whole-word single transfers are used, so size is not decoded
    assign accept = i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hready;
    assign tf_hit = (host_ff.idx[9:3] == TF_DATA_OFS[9:3]);
    // Data port only moves while the drive is ready for the next word
    assign go     = (host_ff.idx != TF_DATA_OFS) || tf_bus.iordy;

    always_comb begin
        nxt_host = host_ff;
        case (host_ff.st)
            HS_IDLE, HS_RESP: begin
                nxt_host.st = HS_IDLE;
                if (accept) begin
                    nxt_host.idx   = i_haddr[11:2];
                    nxt_host.write = i_hwrite;
                    nxt_host.st    = HS_LATCH;
                end
            end
            HS_LATCH: begin
                nxt_host.wdata  = i_hwdata[15:0];
                nxt_host.hrdata = 32'h0000_0000;
                nxt_host.st     = HS_RESP;
                if (host_ff.idx == HOST_STATUS_OFS && !host_ff.write) begin
                    nxt_host.hrdata[HST_INTRQ_BIT]   = tf_bus.intrq;
                    nxt_host.hrdata[HST_REFUSED_BIT] = host_ff.refused;
                end else if (tf_hit) begin
                    nxt_host.st = HS_STROBE;
                    if (host_ff.write && host_ff.idx == TF_COUNT_OFS) begin
                        nxt_host.sc_shadow = i_hwdata[7:0];
                    end
                    if (host_ff.write && host_ff.idx == TF_CMD_OFS) begin
                        nxt_host.refused = 1'b0;
                        if (i_hwdata[7:0] == CMD_WRITE_MULTI
                            && host_ff.sc_shadow == 8'h00) begin
                            nxt_host.refused = 1'b1;
                            nxt_host.st      = HS_RESP;
                        end
                    end
                end
            end
            HS_STROBE: begin
                if (go) begin
                    nxt_host.st = host_ff.write ? HS_RESP : HS_CAPTURE;
                end
            end
            HS_CAPTURE: begin
                nxt_host.hrdata = {16'h0000, tf_bus.rdata};
                nxt_host.st     = HS_RESP;
            end
            default: nxt_host.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            host_ff <= '0;
        end else begin
            host_ff <= nxt_host;
        end
    end

    assign o_hreadyout  = (host_ff.st == HS_IDLE) || (host_ff.st == HS_RESP);
    assign o_hrdata     = host_ff.hrdata;
    assign o_hresp      = 1'b0;
    assign tf_bus.addr  = host_ff.idx[2:0];
    assign tf_bus.wdata = host_ff.wdata;
    assign tf_bus.wr    = (host_ff.st == HS_STROBE) && host_ff.write && go;
    assign tf_bus.rd    = (host_ff.st == HS_STROBE) && !host_ff.write && go;
endmodule

// ===== tb/dwc_tf_properties.sv
// Task-file link checks between host and drive ends
`timescale 1ns/10ps
module dwc_tf_properties (
    input wire logic            i_clk,
    input wire logic            i_resetn,
    input wire logic [2:0]      addr,
    input wire logic            wr,
    input wire logic            rd,
    input dwc_pkg::dwc_word_type wdata,
    input dwc_pkg::dwc_word_type rdata,
    input wire logic            iordy,
    input wire logic            intrq
);
    import dwc_pkg::*;
    logic [7:0] cmd_ff;
    logic       seen_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cmd_ff  <= 8'h00;
            seen_ff <= 1'b0;
        end else if (wr && addr == 3'h7) begin
            cmd_ff  <= wdata[7:0];
            seen_ff <= 1'b1;
        end
    end
    sequence cmd_wr_s; wr && addr == 3'h7; endsequence
    sequence drq_one_s; $rose(iordy) && cmd_ff[7:1] == CMD_WRITE_SEC[7:1]; endsequence
    wr_pulse_a: assert property (wr |=> !wr) else $error("write strobe too long");
    rd_pulse_a: assert property (rd |=> !rd) else $error("read strobe too long");
    rw_excl_a: assert property (!(wr && rd)) else $error("read and write together");
    data_gate_a: assert property (wr && addr == 3'h0 |-> iordy) else $error("data not gated");
    cmd_busy_a: assert property (cmd_wr_s |=> !iordy) else $error("ready at command");
    quiet_a: assert property (!seen_ff |-> !intrq && !iordy) else $error("unprompted");
    sector_irq_a: assert property (drq_one_s |-> intrq) else $error("no sector irq");
    rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("rdata moved");
endmodule

// ===== tb/tb_disk_write_command_engine.sv
// Self-checking bench: host and drive ends joined over the task file
`timescale 1ns/10ps
module tb_disk_write_command_engine;
    import dwc_pkg::*;
    localparam int SW = 4;
    localparam logic [31:0] ST_A = 32'h000007DC;
    logic i_clk = 1'b0, i_resetn = 1'b0, hwrite = 1'b0, hready, wv, cm, lba, nr, sreq;
    logic mdone = 1'b0, merr = 1'b0, sdone = 1'b0, irq_q = 1'b0, elba, enr;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h38;
    logic [1:0] htrans = 2'h0;
    logic [15:0] cyl, scyl, sq_cyl = 16'h0, ecyl;
    dwc_word_type wd, sent_q[$], med_q[$];
    dwc_byte_type sec;
    int error_cnt = 0, samples_checked = 0, dcnt = 0, scnt = 0, commits, irqs, err_at, es;
    dwc_if tf_bus ();
    dwc_host dwc_host_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(), .tf_bus(tf_bus));
    dwc_device #(.P_SECTOR_WORDS(SW)) dwc_device_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .tf_bus(tf_bus), .o_med_wvalid(wv), .o_med_wdata(wd), .o_med_commit(cm),
        .o_med_cyl(cyl), .o_med_head(), .o_med_sector(sec), .o_med_lba_mode(lba),
        .o_med_no_retry(nr), .i_med_done(mdone), .i_med_error(merr), .i_med_fault(8'h40),
        .o_seek_req(sreq), .o_seek_cyl(scyl), .i_seek_done(sdone));
    dwc_tf_properties dwc_tf_properties_i (.i_clk(i_clk), .i_resetn(i_resetn),
        .addr(tf_bus.addr), .wr(tf_bus.wr), .rd(tf_bus.rd), .wdata(tf_bus.wdata),
        .rdata(tf_bus.rdata), .iordy(tf_bus.iordy), .intrq(tf_bus.intrq));
    always #10 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // ****************************************
    // Medium and seek responder
    // ****************************************
    task automatic commit_chk();
        dwc_word_type x, c;
        x = 16'h0;
        c = CRC_INIT;
        chk("words", 32'(med_q.size()), SW + 2);
        for (int i = 0; i < SW; i++) begin
            x ^= med_q[i];
            for (int b = 15; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ med_q[i][b]) ? CRC_POLY : 16'h0);
            chk("data", med_q[i], sent_q.pop_front());
        end
        chk("crc", med_q[SW], c);
        chk("ecc", med_q[SW + 1], x);
        if (commits < 40) chk("sector", sec, es + commits);
        chk("track", cyl, sq_cyl);
        chk("mode bits", {lba, nr}, {elba, enr});
        med_q.delete();
        commits++;
        dcnt = 4;
    endtask
    always @(posedge i_clk) begin
        mdone <= dcnt == 1;
        merr <= dcnt == 1 && commits == err_at;
        sdone <= scnt == 1;
        irq_q <= tf_bus.intrq;
        if (tf_bus.intrq && !irq_q) irqs++;
        if (dcnt > 0) dcnt--;
        if (scnt > 0) scnt--;
        if (sreq) begin
            scnt = 6;
            sq_cyl <= scyl;
        end
        if (wv) med_q.push_back(wd);
        if (cm) commit_chk();
    end
    task automatic run_cmd(input dwc_byte_type cmd, input int n, input int bs, input int err);
        logic [31:0] q, r;
        int tot, att;
        r = rnd();
        tot = n == 0 ? 256 : n;
        es = 1 + r[3:0];
        ecyl = {14'h0, r[5:4]};
        elba = n == 0 ? 1'b0 : r[6];
        enr = cmd[0];
        err_at = err;
        commits = 0;
        irqs = 0;
        bus(32'h7C8, 1'b1, 32'(n), q);
        bus(32'h7CC, 1'b1, 32'(es), q);
        bus(32'h7D0, 1'b1, {16'h0, ecyl}, q);
        bus(32'h7D8, 1'b1, {25'h0, elba, 6'h0}, q);
        bus(32'h7DC, 1'b1, {24'h0, cmd}, q);
        forever begin
            do bus(ST_A, 1'b0, 32'h0, q); while (q[ST_BSY] !== 1'b0);
            if (q[ST_DRQ] !== 1'b1) break;
            repeat (SW) begin
                r = rnd();
                sent_q.push_back(r[15:0]);
                bus(32'h7C0, 1'b1, r, q);
            end
        end
        att = err != 0 ? err : bs == 0 ? 0 : tot;
        chk("status", q[7:0], {7'h28, err != 0 || bs == 0});
        chk("commits", commits, att);
        chk("irqs", irqs, bs == 0 ? 1 : (att + bs - 1) / bs + 1);
        bus(32'h7C4, 1'b0, 32'h0, q);
        if (att != tot) chk("fault", q[7:0], bs == 0 ? FAULT_ABORT : 8'h40);
        bus(32'h7C8, 1'b0, 32'h0, q);
        if (bs != 0) chk("count", q[7:0], err != 0 ? tot - err + 1 : 0);
        bus(32'h7CC, 1'b0, 32'h0, q);
        if (bs == 1 && tot < 8) chk("last sector", q[7:0], es + att - 1);
    endtask
    initial begin
        logic [31:0] q, r;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        bus(ST_A, 1'b0, 32'h0, q);
        chk("idle status", q[7:0], 8'h50);
        bus(32'h7F0, 1'b0, 32'h0, q);
        chk("unmapped", q, 32'h0);
        run_cmd(CMD_WRITE_MULTI, 2, 0, 0);
        bus(32'h7C8, 1'b1, 32'h0, q);
        bus(32'h7DC, 1'b1, {24'h0, CMD_WRITE_MULTI}, q);
        bus(32'h7E0, 1'b0, 32'h0, q);
        chk("refused", q, 32'h2);
        bus(32'h7C8, 1'b1, 32'h2, q);
        bus(32'h7DC, 1'b1, {24'h0, CMD_SET_MULTI}, q);
        bus(ST_A, 1'b0, 32'h0, q);
        run_cmd(CMD_WRITE_SEC, 0, 1, 0);
        run_cmd(CMD_WRITE_SEC, 3, 1, 2);
        run_cmd(CMD_WRITE_MULTI, 4, 2, 2);
        repeat (10) begin
            r = rnd();
            if (r[0]) run_cmd(CMD_WRITE_MULTI, 1 + r[3:1], 2, 0);
            else run_cmd({7'h18, r[1]}, 1 + r[3:2], 1, 0);
        end
        final_report();
    end
    // Cut a hang well past the longest expected run
    initial begin
        #1500000;
        error_cnt++;
        final_report();
    end
endmodule
